// ===== design/phy_mgmt_pkg.sv
// constants and carrier types for the phy control and status register bank
`default_nettype none
package phy_mgmt_pkg;
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned NS_PER_US      = 1000;
   // descrambler dead time after loopback entry, longest figure, rounded down
   localparam int unsigned DEAD_TIME_NS   = 560;
   localparam int unsigned DEAD_TIME_CYC  = (DEAD_TIME_NS * CLK_MHZ) / NS_PER_US;
   // internal soft reset action length, least time, rounded up
   localparam int unsigned SRST_NS        = 1000;
   localparam int unsigned SRST_CYC       = (SRST_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   localparam int          CNT_W          = 8;

   localparam int          ADDR_W         = 5;
   localparam int          DATA_W         = 16;
   localparam logic [4:0]  ADDR_CTRL      = 5'h00;
   localparam logic [4:0]  ADDR_STAT      = 5'h01;

   localparam int          CTRL_RESET     = 15;
   localparam int          CTRL_LOOPBACK  = 14;
   localparam int          CTRL_SPEED     = 13;
   localparam int          CTRL_AN_EN     = 12;
   localparam int          CTRL_PWR_DOWN  = 11;
   localparam int          CTRL_AN_RESTART = 9;
   localparam int          CTRL_DUPLEX    = 8;
   localparam int          CTRL_COL_TEST  = 7;
   localparam logic [15:0] CTRL_DEFAULT   = 16'h3000;
   localparam logic [15:0] CTRL_WR_MASK   = 16'hFB80;

   localparam int          STAT_AN_DONE   = 5;
   localparam int          STAT_LINK      = 2;
   localparam int          STAT_JABBER    = 1;
   localparam logic [15:0] STAT_CONST     = 16'h7809;

   localparam logic [CNT_W-1:0] DEAD_LOAD = CNT_W'(DEAD_TIME_CYC);
   localparam logic [CNT_W-1:0] SRST_LOAD = CNT_W'(SRST_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
   localparam logic [15:0]      DATA_ZERO = 16'h0000;
   localparam logic [3:0]       NIB_ZERO  = 4'h0;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
   } reg_rsp_t;

   typedef struct packed {
      logic       en;
      logic [3:0] data;
   } nibble_t;

   typedef struct packed {
      logic ovr;
      logic val;
   } loop_cfg_t;

   typedef struct packed {
      logic speed_100;
      logic duplex_full;
      logic complete;
   } an_result_t;

   typedef enum logic [0:0] {
      SEQ_IDLE,
      SEQ_BUSY
   } seq_state_t;
endpackage : phy_mgmt_pkg
`default_nettype wire

// ===== design/phy_soft_reset_seq.sv
// sequencer that times the self-clearing soft reset action
`default_nettype none
module phy_soft_reset_seq (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   input  wire logic start,
   output var  logic busy_q,
   output var  logic done_q
);
   import phy_mgmt_pkg::*;

   typedef struct packed {
      seq_state_t       st;
      logic [CNT_W-1:0] cnt;
      logic             busy;
      logic             done;
   } seq_t;

   seq_t s_q;
   seq_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         SEQ_IDLE: begin
            if (start) begin
               s_d.st   = SEQ_BUSY;
               s_d.cnt  = SRST_LOAD;
               s_d.busy = 1'b1;
            end
         end
         SEQ_BUSY: begin
            // a second start while busy is absorbed, the action is not stretched
            if (s_q.cnt == CNT_ONE) begin
               s_d.st   = SEQ_IDLE;
               s_d.cnt  = CNT_ZERO;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - CNT_ONE;
            end
         end
         default: begin
            s_d.st   = SEQ_IDLE;
            s_d.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{st: SEQ_IDLE, cnt: CNT_ZERO, busy: 1'b0, done: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign busy_q = s_q.busy;
   assign done_q = s_q.done;
endmodule : phy_soft_reset_seq
`default_nettype wire

// ===== design/phy_mgmt_control_status_regs.sv
// basic control and status registers of the phy unit with their line effects
// Behaviour
// - control bit 15 restores defaults, self clears
// - reset bit reads 1 until reset done
// - bit 14 loops transmit nibbles, isolates receiver
// - loopback entry gives 560 ns receive dead time
// - configuration loopback setting overrides bit 14
// - bit 13 picks speed, auto-negotiation off
// - bit 12 enables auto-negotiation, ignores 13/8
// - bit 11 selects low power state
// - bit 9 restarts auto-negotiation, self clears
// - bit 8 picks duplex, auto-negotiation off
// - loopback behaviour ignores duplex bit
// - bit 7 forces collision on transmit enable
// - status bits 14..11 read constant one
// - status bit 6 reads zero, preamble required
// - status bit 5 shows auto-negotiation done
// - status bit 2 link, latch low
// - status bit 1 jabber, latch high
// - status bit 3 reads constant one
// - status bit 0 one, bit 4 zero
`default_nettype none
module phy_mgmt_control_status_regs (
   input  wire logic                     ref_clk,
   input  wire logic                     arst_n,
   input  wire phy_mgmt_pkg::reg_req_t   reg_req,
   output var  phy_mgmt_pkg::reg_rsp_t   reg_rsp_q,
   input  wire phy_mgmt_pkg::nibble_t    tx_nib,
   input  wire phy_mgmt_pkg::nibble_t    line_rx_nib,
   output var  phy_mgmt_pkg::nibble_t    rx_nib_q,
   input  wire phy_mgmt_pkg::loop_cfg_t  loop_cfg,
   input  wire phy_mgmt_pkg::an_result_t an_result,
   input  wire logic                     link_ok,
   input  wire logic                     jabber_det,
   output var  logic                     loopback_q,
   output var  logic                     rx_isolate_q,
   output var  logic                     speed_100_q,
   output var  logic                     duplex_full_q,
   output var  logic                     power_down_q,
   output var  logic                     an_enable_q,
   output var  logic                     an_restart_q,
   output var  logic                     collision_q,
   output var  logic                     soft_reset_busy_q
);
   import phy_mgmt_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] ctrl;
      logic              link_ll;
      logic              jab_lh;
      reg_rsp_t          rsp;
      nibble_t           rx;
      logic [CNT_W-1:0]  dead_cnt;
      logic              loop;
      logic              isolate;
      logic              speed_100;
      logic              duplex_full;
      logic              power_down;
      logic              an_en;
      logic              an_restart;
      logic              col;
   } state_t;

   localparam state_t STATE_RESET = '{
      ctrl:        CTRL_DEFAULT,
      link_ll:     1'b0,
      jab_lh:      1'b0,
      rsp:         '{rvalid: 1'b0, rdata: DATA_ZERO},
      rx:          '{en: 1'b0, data: NIB_ZERO},
      dead_cnt:    CNT_ZERO,
      loop:        1'b0,
      isolate:     1'b0,
      speed_100:   1'b1,
      duplex_full: 1'b0,
      power_down:  1'b0,
      an_en:       1'b1,
      an_restart:  1'b0,
      col:         1'b0
   };

   function automatic logic hit(input reg_req_t req, input logic [ADDR_W-1:0] a);
      hit = (req.addr == a);
   endfunction : hit

   function automatic logic power_down_eff(input logic [DATA_W-1:0] c);
      power_down_eff = c[CTRL_PWR_DOWN];
   endfunction : power_down_eff

   // the reset bit reads as set for the whole action, done cycle included
   function automatic logic [DATA_W-1:0] ctrl_word(input logic [DATA_W-1:0] c,
                                                    input logic              busy);
      ctrl_word             = c;
      ctrl_word[CTRL_RESET] = busy;
   endfunction : ctrl_word

   // constant abilities, preamble needed, no remote fault, reserved bits zero
   function automatic logic [DATA_W-1:0] stat_word(input logic done,
                                                    input logic link,
                                                    input logic jab);
      stat_word               = STAT_CONST;
      stat_word[STAT_AN_DONE] = done;
      stat_word[STAT_LINK]    = link;
      stat_word[STAT_JABBER]  = jab;
   endfunction : stat_word

   state_t s_q;
   state_t s_d;
   logic   srst_busy;
   logic   srst_done;
   logic   srst_start;
   logic   ctrl_wr;
   logic   stat_rd;
   logic   loop_eff;

   // reset request is taken only when idle, so a busy pulse cannot retrigger
   assign srst_start = ctrl_wr && reg_req.wdata[CTRL_RESET];

   phy_soft_reset_seq u_srst (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .start   (srst_start),
      .busy_q  (srst_busy),
      .done_q  (srst_done)
   );

   always_comb begin
      // writes are not serviced while the reset action runs
      ctrl_wr  = reg_req.wr && hit(reg_req, ADDR_CTRL) && !srst_busy;
      stat_rd  = reg_req.rd && hit(reg_req, ADDR_STAT) && !srst_busy;
      // configuration setting decides when it is asserted
      loop_eff = loop_cfg.ovr ? loop_cfg.val : s_q.ctrl[CTRL_LOOPBACK];
   end

   always_comb begin
      s_d = s_q;

      // control register write path
      if (ctrl_wr) begin
         // reserved bits are dropped; only defined bits are kept
         s_d.ctrl = reg_req.wdata & CTRL_WR_MASK;
         s_d.ctrl[CTRL_RESET] = 1'b0;
      end

      // self-clearing restart: one-cycle pulse out, bit never stays set
      s_d.an_restart = 1'b0;
      if (s_q.ctrl[CTRL_AN_RESTART]) begin
         s_d.an_restart = 1'b1;
         s_d.ctrl[CTRL_AN_RESTART] = 1'b0;
      end

      // latched status flags; a read reloads from the present condition,
      // so an event in the read cycle is never lost
      if (stat_rd) begin
         s_d.link_ll = link_ok;
         s_d.jab_lh  = jabber_det;
      end else begin
         s_d.link_ll = s_q.link_ll & link_ok;
         s_d.jab_lh  = s_q.jab_lh | jabber_det;
      end

      // a status write falls through with no branch that stores it

      // effective modes from the control bits
      s_d.loop        = loop_eff;
      s_d.isolate     = loop_eff;
      s_d.power_down  = s_q.ctrl[CTRL_PWR_DOWN];
      s_d.an_en       = s_q.ctrl[CTRL_AN_EN];
      if (s_q.ctrl[CTRL_AN_EN]) begin
         // forced speed and duplex are ignored here
         s_d.speed_100   = an_result.speed_100;
         s_d.duplex_full = an_result.duplex_full;
      end else begin
         s_d.speed_100   = s_q.ctrl[CTRL_SPEED];
         s_d.duplex_full = s_q.ctrl[CTRL_DUPLEX];
      end
      // both duplex modes are supported, so the bit is held as written;
      // loopback runs full duplex whatever the bit says
      if (loop_eff) begin
         s_d.duplex_full = 1'b1;
      end

      // forced collision follows transmit enable
      s_d.col = s_q.ctrl[CTRL_COL_TEST] && tx_nib.en;

      // dead time starts on the rising edge of effective loopback
      if (loop_eff && !s_q.loop) begin
         s_d.dead_cnt = DEAD_LOAD;
      end else if (s_q.dead_cnt != CNT_ZERO) begin
         s_d.dead_cnt = s_q.dead_cnt - CNT_ONE;
      end

      // receive nibble path
      if (power_down_eff(s_q.ctrl)) begin
         s_d.rx = '{en: 1'b0, data: NIB_ZERO};
      end else if (loop_eff) begin
         // network side is not looked at while looping back
         s_d.rx = tx_nib;
         if (s_q.dead_cnt != CNT_ZERO || !s_q.loop) begin
            // descrambler resync window: nothing valid is delivered
            s_d.rx.en = 1'b0;
         end
      end else begin
         s_d.rx = line_rx_nib;
      end

      // completion of the soft reset returns every register to default
      if (srst_done) begin
         s_d = STATE_RESET;
      end

      // read response, one cycle after the request; built after the reset
      // so a read in the cycle that ends the reset is still answered
      s_d.rsp.rvalid = reg_req.rd;
      s_d.rsp.rdata  = DATA_ZERO;
      if (reg_req.rd && hit(reg_req, ADDR_CTRL)) begin
         // defaults only show the cycle after done, so done still reads busy
         s_d.rsp.rdata = ctrl_word(s_q.ctrl, srst_busy || srst_start || srst_done);
      end else if (reg_req.rd && hit(reg_req, ADDR_STAT)) begin
         s_d.rsp.rdata = stat_word(an_result.complete, s_q.link_ll, s_q.jab_lh);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= STATE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rsp_q         = s_q.rsp;
   assign rx_nib_q          = s_q.rx;
   assign loopback_q        = s_q.loop;
   assign rx_isolate_q      = s_q.isolate;
   assign speed_100_q       = s_q.speed_100;
   assign duplex_full_q     = s_q.duplex_full;
   assign power_down_q      = s_q.power_down;
   assign an_enable_q       = s_q.an_en;
   assign an_restart_q      = s_q.an_restart;
   assign collision_q       = s_q.col;
   assign soft_reset_busy_q = srst_busy;
endmodule : phy_mgmt_control_status_regs
`default_nettype wire

// ===== sim/phy_regs_monitor.sv
// concurrent checks on the phy control and status register bank ports
`default_nettype none
module phy_regs_chk
   import phy_mgmt_pkg::*;
(
   input wire logic                     ref_clk,
   input wire logic                     arst_n,
   input wire phy_mgmt_pkg::reg_req_t   reg_req,
   input wire phy_mgmt_pkg::reg_rsp_t   reg_rsp_q,
   input wire phy_mgmt_pkg::nibble_t    tx_nib,
   input wire phy_mgmt_pkg::nibble_t    rx_nib_q,
   input wire phy_mgmt_pkg::loop_cfg_t  loop_cfg,
   input wire phy_mgmt_pkg::an_result_t an_result,
   input wire logic                     loopback_q,
   input wire logic                     rx_isolate_q,
   input wire logic                     speed_100_q,
   input wire logic                     power_down_q,
   input wire logic                     an_enable_q,
   input wire logic                     an_restart_q,
   input wire logic                     collision_q,
   input wire logic                     soft_reset_busy_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   rd_answer_a: assert property (reg_req.rd |=> reg_rsp_q.rvalid)
      else $error("read not answered");
   rvalid_cause_a: assert property (reg_rsp_q.rvalid |-> $past(reg_req.rd))
      else $error("answer without read");
   srst_start_a: assert property (reg_req.wr && reg_req.addr == ADDR_CTRL
      && reg_req.wdata[15] && !soft_reset_busy_q |=> soft_reset_busy_q)
      else $error("soft reset not started");
   srst_end_a: assert property ($fell(soft_reset_busy_q) |=>
      an_enable_q && speed_100_q && !power_down_q && !loopback_q)
      else $error("defaults not restored");
   stat_fixed_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == ADDR_STAT
      |-> (reg_rsp_q.rdata & 16'hFFD9) == 16'h7809)
      else $error("status fixed bits wrong");
   loop_iso_a: assert property (loopback_q == rx_isolate_q)
      else $error("isolate differs from loopback");
   cfg_wins_a: assert property (loop_cfg.ovr |=> loopback_q == $past(loop_cfg.val))
      else $error("loopback setting ignored");
   an_speed_a: assert property (an_enable_q |-> speed_100_q == $past(an_result.speed_100))
      else $error("speed not from negotiation");
   pd_quiet_a: assert property (power_down_q && $past(power_down_q) |-> rx_nib_q == '0)
      else $error("receive active in power down");
   restart_once_a: assert property (an_restart_q |=> !an_restart_q)
      else $error("restart pulse too long");
   no_col_a: assert property (!$past(tx_nib.en) |-> !collision_q)
      else $error("collision without transmit");
endmodule : phy_regs_chk

bind phy_mgmt_control_status_regs phy_regs_chk u_chk (.ref_clk, .arst_n, .reg_req,
   .reg_rsp_q, .tx_nib, .rx_nib_q, .loop_cfg, .an_result, .loopback_q, .rx_isolate_q,
   .speed_100_q, .power_down_q, .an_enable_q, .an_restart_q, .collision_q,
   .soft_reset_busy_q);
`default_nettype wire

// ===== sim/mgmt_ctrl_model.sv
// management controller model issuing register reads and writes
`default_nettype none
module mgmt_ctrl_model
   import phy_mgmt_pkg::*;
(
   input  wire logic                   ref_clk,
   output var  phy_mgmt_pkg::reg_req_t reg_req,
   input  wire phy_mgmt_pkg::reg_rsp_t reg_rsp_q
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req = '0;

   // callers keep reserved control bits clear, frames always whole
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge ref_clk);
      reg_req.wr    <= 1'b0;
      reg_req.addr  <= ~a;
      reg_req.wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge ref_clk);
      reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~reg_req.wdata};
      @(posedge ref_clk);
      reg_req.rd   <= 1'b0;
      reg_req.addr <= ~a;
      #1;
      q = reg_rsp_q.rdata;
   endtask : rd

   // no normal service until the reset bit reads back clear
   task automatic wait_ready(output logic ok);
      logic [15:0] q;
      ok = 1'b0;
      for (int i = 0; i < 400 && !ok; i++) begin
         rd(ADDR_CTRL, q);
         ok = (q[15] === 1'b0);
      end
   endtask : wait_ready
endmodule : mgmt_ctrl_model
`default_nettype wire

// ===== sim/tb_phy_mgmt_control_status_regs.sv
// register-level tests of the phy control and status register bank
`default_nettype none
module tb_phy_mgmt_control_status_regs
   import phy_mgmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       ref_clk, arst_n, link_ok, jabber_det, ok;
   reg_req_t   reg_req;
   reg_rsp_t   reg_rsp_q;
   nibble_t    tx_nib, line_rx_nib, rx_nib_q;
   loop_cfg_t  loop_cfg;
   an_result_t an_result;
   logic       loopback_q, rx_isolate_q, speed_100_q, duplex_full_q, power_down_q;
   logic       an_enable_q, an_restart_q, collision_q, soft_reset_busy_q;
   int         bad_count, total_checks, pulses;

   phy_mgmt_control_status_regs u_dut (.ref_clk, .arst_n, .reg_req, .reg_rsp_q, .tx_nib,
      .line_rx_nib, .rx_nib_q, .loop_cfg, .an_result, .link_ok, .jabber_det, .loopback_q,
      .rx_isolate_q, .speed_100_q, .duplex_full_q, .power_down_q, .an_enable_q,
      .an_restart_q, .collision_q, .soft_reset_busy_q);
   mgmt_ctrl_model u_mgr (.ref_clk, .reg_req, .reg_rsp_q);

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic rc(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      u_mgr.rd(a, q);
      chk(q, e);
   endtask : rc

   // outputs lag a write by one edge, two spare for margin
   task automatic settle;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done

   always @(posedge ref_clk) begin
      if (an_restart_q === 1'b1) pulses <= pulses + 1;
   end

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   initial begin
      #50000;
      bad_count++;
      test_done();
   end

   initial begin
      arst_n = 1'b0;
      link_ok = 1'b0;
      jabber_det = 1'b0;
      tx_nib = '0;
      line_rx_nib = '{en: 1'b1, data: 4'h5};
      loop_cfg = '0;
      an_result = '{speed_100: 1'b1, duplex_full: 1'b1, complete: 1'b0};
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      rc(ADDR_CTRL, 16'h3000);
      chk(16'({speed_100_q, an_enable_q, power_down_q}), 16'h0006);
      @(posedge ref_clk);
      link_ok <= 1'b1;
      rc(ADDR_STAT, 16'h7809);
      rc(ADDR_STAT, 16'h780D);
      @(posedge ref_clk);
      link_ok <= 1'b0;
      @(posedge ref_clk);
      link_ok <= 1'b1;
      jabber_det <= 1'b1;
      @(posedge ref_clk);
      jabber_det <= 1'b0;
      rc(ADDR_STAT, 16'h780B);
      rc(ADDR_STAT, 16'h780D);
      @(posedge ref_clk);
      an_result.complete <= 1'b1;
      rc(ADDR_STAT, 16'h782D);
      u_mgr.wr(ADDR_STAT, 16'hFFFF);
      rc(ADDR_CTRL, 16'h3000);
      rc(5'h1F, 16'h0000);
      u_mgr.wr(ADDR_CTRL, 16'h2100);
      settle();
      chk(16'({speed_100_q, duplex_full_q}), 16'h0003);
      u_mgr.wr(ADDR_CTRL, 16'h0000);
      settle();
      chk(16'({speed_100_q, duplex_full_q}), 16'h0000);
      u_mgr.wr(ADDR_CTRL, 16'h1000);
      settle();
      chk(16'({speed_100_q, duplex_full_q}), 16'h0003);
      u_mgr.wr(ADDR_CTRL, 16'h1200);
      settle();
      rc(ADDR_CTRL, 16'h1000);
      chk(16'(pulses), 16'h0001);
      u_mgr.wr(ADDR_CTRL, 16'h0080);
      @(posedge ref_clk);
      tx_nib <= '{en: 1'b1, data: 4'hA};
      settle();
      chk(16'(collision_q), 16'h0001);
      u_mgr.wr(ADDR_CTRL, 16'h0800);
      settle();
      chk(16'({power_down_q, collision_q}), 16'h0002);
      u_mgr.wr(ADDR_CTRL, 16'h4000);
      settle();
      // loopback forces full duplex although bit 8 is clear
      chk(16'({loopback_q, rx_isolate_q, duplex_full_q, rx_nib_q.en}), 16'h000E);
      repeat (150) @(posedge ref_clk);
      #1;
      chk(16'(rx_nib_q), 16'h001A);
      @(posedge ref_clk);
      loop_cfg <= '{ovr: 1'b1, val: 1'b0};
      settle();
      chk(16'({loopback_q, rx_nib_q}), 16'h0015);
      @(posedge ref_clk);
      loop_cfg <= '0;
      u_mgr.wr(ADDR_CTRL, 16'h8000);
      rc(ADDR_CTRL, 16'h8000);
      chk(16'(soft_reset_busy_q), 16'h0001);
      u_mgr.wait_ready(ok);
      chk(16'(ok), 16'h0001);
      rc(ADDR_CTRL, 16'h3000);
      rc(ADDR_STAT, 16'h7829);
      test_done();
   end
endmodule : tb_phy_mgmt_control_status_regs
`default_nettype wire
